// ==== shared/adc_pd_pkg.sv ====
`default_nettype none
package adc_pd_pkg;
  // Serial frame geometry
  localparam int FRAME_EDGES = 16;
  localparam logic [4:0] EDGE_PD_LOW = 5'h02;
  localparam logic [4:0] EDGE_KEEP_UP = 5'h0A;
  localparam logic [4:0] EDGE_LAST = 5'h10;
  localparam logic [4:0] EDGE_TRACK = 5'h0D;
  localparam int DATA_BITS = 12;
  localparam int LEAD_ZEROS = 4;
  // Wake time
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_TIME_NS = 1000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [7:0] WAKE_CYCLES_W = 8'(WAKE_CYCLES);
  // Host serial clock half period in system clocks (80 ns period)
  localparam logic [2:0] SCLK_HALF = 3'h4;
  // Quiet interval after release, in system clocks
  localparam logic [2:0] QUIET_CYCLES = 3'h3;
  localparam logic [11:0] DATA_RESET = 12'h000;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_WAKING = 2'b01,
    PWR_DOWN = 2'b11
  } pwr_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW = 3'b001,
    H_HIGH = 3'b011,
    H_END = 3'b010,
    H_QUIET = 3'b110
  } host_state_type;

  typedef enum logic [1:0] {
    OP_FULL = 2'b00,
    OP_POWER_DOWN = 2'b01,
    OP_STOP_AFTER = 2'b10
  } op_type;
endpackage
`default_nettype wire

// ==== shared/adc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic frame_sel_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe;
  modport device (
    input frame_sel_n,
    input sclk,
    output serial_result_out,
    output serial_result_oe
  );
  modport host (
    output frame_sel_n,
    output sclk,
    input serial_result_out,
    input serial_result_oe
  );
endinterface
`default_nettype wire

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Pins
  input wire logic [1:0] i_pin,
  output logic [1:0] o_sync
);
  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
  } sync_state_type;
  sync_state_type state;
  sync_state_type next_state;

  always_comb begin
    next_state.first = i_pin;
    next_state.second = state.first;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= '{first: 2'h3, second: 2'h3};
    end else begin
      state <= next_state;
    end
  end

  assign o_sync = state.second;
endmodule
`default_nettype wire

// ==== rtl/adc_pd_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Rise after edge 2, before 10: power down
// [R2] Power-down entry aborts frame, releases output
// [R3] Rise before edge 2 keeps normal mode
// [R4] Wake starts at fall, needs 10 edges
// [R5] Powered 1 us after fall; next valid
// [R6] Early rise while waking returns to power-down
// [R7] Power-down: analog off, sampler holds
// [R8] Sampler tracks on first clock edge; code does so only in waking frames, else at the rise after fall 13
// [R9] Host waits quiet time after release
// [R10] One dummy frame suffices up to 18MHz
// [R11] Host may end dummy after edge 10
// [R12] Host runs dummy frame after supply
// [R13] Dummy frame allowed right after supply
// [R14] Sampler tracks at power-on
// [R15] Above 320kSPS lower serial clock
// [R16] Normal mode needs 10 edges low
// [R17] Rise between 10 and 16 aborts only
// [R18] Frame is 16 clocks; release on 16th
// [R19] Four zeros then 12 bits MSB first
// [R20] Counter clears at fall; decide at rise
module adc_pd_device (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Link
  adc_link_if.device link,
  // Converter side
  input wire logic [11:0] i_sample,
  output logic o_analog_on,
  output logic o_tracking,
  output logic o_powered,
  output logic [11:0] o_result
);
  typedef struct packed {
    adc_pd_pkg::pwr_type pwr;
    logic cs_d;
    logic sclk_d;
    logic active;
    logic [4:0] falls;
    logic [15:0] shreg;
    logic sdo;
    logic oe;
    logic track;
    logic [7:0] wake_cnt;
    logic powered;
    logic [11:0] result;
    logic [11:0] sample;
    logic analog;
  } dev_state_type;
  dev_state_type state;
  dev_state_type next_state;
  logic [1:0] pins;

  pin_sync sync_inst (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_pin({link.frame_sel_n, link.sclk}),
    .o_sync(pins)
  );

  wire cs_n = pins[1];
  wire sclk = pins[0];
  wire cs_fall;
  wire cs_rise;
  wire sclk_fall;
  wire sclk_rise;

  // High for one cycle when a synchronised pin goes low
  function automatic logic fell(input logic prev, input logic now);
    return prev && !now;
  endfunction

  // High for one cycle when a synchronised pin goes high
  function automatic logic rose(input logic prev, input logic now);
    return !prev && now;
  endfunction

  // Falling-edge count including the edge being taken now
  function automatic logic [4:0] fall_count(input logic [4:0] falls);
    return falls + 5'h01;
  endfunction

  // Power state chosen when frame select rises inside a frame
  function automatic adc_pd_pkg::pwr_type rise_state(
    input adc_pd_pkg::pwr_type pwr,
    input logic [4:0] falls
  );
    adc_pd_pkg::pwr_type res;
    res = pwr;
    if (falls < adc_pd_pkg::EDGE_KEEP_UP) begin
      if (pwr == adc_pd_pkg::PWR_WAKING) begin
        res = adc_pd_pkg::PWR_DOWN; // [R6]
      end else if (falls >= adc_pd_pkg::EDGE_PD_LOW) begin
        res = adc_pd_pkg::PWR_DOWN; // [R1]
      end
    end
    return res;
  endfunction

  assign cs_fall = fell(state.cs_d, cs_n);
  assign cs_rise = rose(state.cs_d, cs_n);
  assign sclk_fall = fell(state.sclk_d, sclk);
  assign sclk_rise = rose(state.sclk_d, sclk);

  always_comb begin
    next_state = state;
    next_state.cs_d = cs_n;
    next_state.sclk_d = sclk;
    // Wake timer keeps running after waking ends early at edge 10
    if (state.pwr != adc_pd_pkg::PWR_DOWN &&
        state.wake_cnt != adc_pd_pkg::WAKE_CYCLES_W) begin
      next_state.wake_cnt = state.wake_cnt + 8'h01; // [R5]
    end
    if (cs_fall) begin
      next_state.falls = 5'h00; // [R20]
      next_state.active = 1'b1;
      next_state.oe = 1'b1;
      next_state.sdo = 1'b0;
      next_state.shreg = {{adc_pd_pkg::LEAD_ZEROS{1'b0}}, i_sample}; // [R19]
      next_state.sample = i_sample;
      next_state.track = 1'b0;
      if (state.pwr == adc_pd_pkg::PWR_DOWN) begin
        next_state.pwr = adc_pd_pkg::PWR_WAKING; // [R4]
        next_state.wake_cnt = 8'h00;
      end
    end else if (cs_rise && state.active) begin
      next_state.active = 1'b0;
      next_state.oe = 1'b0; // [R2] [R17]
      next_state.pwr = rise_state(state.pwr, state.falls); // [R20]
      if (next_state.pwr == adc_pd_pkg::PWR_DOWN) begin
        next_state.track = 1'b0; // [R7]
      end else begin
        next_state.track = 1'b1; // [R3] [R16]
      end
    end else if (state.active) begin
      if ((sclk_rise || sclk_fall) && state.falls == 5'h00 &&
          state.pwr == adc_pd_pkg::PWR_WAKING) begin
        next_state.track = 1'b1; // [R8]
      end
      if (sclk_rise && state.falls >= adc_pd_pkg::EDGE_TRACK) begin
        next_state.track = 1'b1;
      end
      if (sclk_fall) begin
        next_state.falls = fall_count(state.falls);
        next_state.sdo = state.shreg[14];
        next_state.shreg = {state.shreg[14:0], 1'b0};
        if (fall_count(state.falls) == adc_pd_pkg::EDGE_KEEP_UP &&
            state.pwr == adc_pd_pkg::PWR_WAKING) begin
          next_state.pwr = adc_pd_pkg::PWR_NORMAL; // [R4] [R10]
        end
        if (fall_count(state.falls) == adc_pd_pkg::EDGE_LAST) begin
          next_state.oe = 1'b0; // [R18]
          next_state.active = 1'b0;
          next_state.result = state.sample;
        end
      end
    end
    next_state.analog = (next_state.pwr != adc_pd_pkg::PWR_DOWN); // [R7]
    next_state.powered = (next_state.pwr != adc_pd_pkg::PWR_DOWN) &&
      (next_state.wake_cnt == adc_pd_pkg::WAKE_CYCLES_W); // [R5]
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= '0;
      state.pwr <= adc_pd_pkg::PWR_NORMAL;
      state.cs_d <= 1'b1;
      state.sclk_d <= 1'b1;
      state.active <= 1'b0;
      state.falls <= 5'h00;
      state.sdo <= 1'b0;
      state.oe <= 1'b0;
      state.track <= 1'b1; // [R14]
      state.wake_cnt <= adc_pd_pkg::WAKE_CYCLES_W;
      state.powered <= 1'b1;
      state.result <= adc_pd_pkg::DATA_RESET;
      state.sample <= adc_pd_pkg::DATA_RESET;
      state.analog <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign link.serial_result_out = state.sdo;
  assign link.serial_result_oe = state.oe;
  assign o_analog_on = state.analog; // [R7]
  assign o_tracking = state.track;
  assign o_powered = state.powered;
  assign o_result = state.result;
endmodule
`default_nettype wire

// ==== rtl/adc_pd_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_pd_host (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Link
  adc_link_if.host link,
  // Command
  input wire logic i_req_valid,
  input wire adc_pd_pkg::op_type i_req_op,
  output logic o_req_ready,
  // Result buffer out
  output logic o_data_valid,
  output logic [11:0] o_data,
  input wire logic i_data_ready
);
  typedef struct packed {
    adc_pd_pkg::host_state_type st;
    adc_pd_pkg::op_type op;
    logic cs_n;
    logic sclk;
    logic [2:0] div;
    logic [4:0] falls;
    logic [15:0] shreg;
    logic [2:0] quiet;
    logic [1:0][11:0] buf_data;
    logic [1:0] buf_valid;
    logic rd_ptr;
    logic wr_ptr;
    logic ready;
    logic head_valid;
    logic [11:0] head_data;
  } host_reg_type;
  host_reg_type state;
  host_reg_type next_state;
  logic [1:0] pins;
  logic push;
  logic pop;
  logic [4:0] stop_edge;

  pin_sync sync_inst (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_pin({link.serial_result_oe, link.serial_result_out}),
    .o_sync(pins)
  );

  always_comb begin
    next_state = state;
    push = 1'b0;
    pop = state.head_valid && i_data_ready;
    stop_edge = (state.op == adc_pd_pkg::OP_POWER_DOWN) ?
      adc_pd_pkg::EDGE_PD_LOW + 5'h01 : adc_pd_pkg::EDGE_KEEP_UP; // [R1] [R11]
    unique case (state.st)
      adc_pd_pkg::H_IDLE: begin
        if (i_req_valid && state.ready &&
            !(&state.buf_valid)) begin
          next_state.op = i_req_op;
          next_state.cs_n = 1'b0;
          next_state.falls = 5'h00;
          next_state.div = 3'h0;
          next_state.st = adc_pd_pkg::H_LOW;
        end
      end
      adc_pd_pkg::H_LOW: begin
        next_state.div = state.div + 3'h1;
        if (state.div + 3'h1 == adc_pd_pkg::SCLK_HALF) begin // [R15]
          next_state.div = 3'h0;
          next_state.sclk = 1'b0;
          next_state.falls = state.falls + 5'h01;
          next_state.shreg = {state.shreg[14:0], pins[0]};
          next_state.st = adc_pd_pkg::H_HIGH;
        end
      end
      adc_pd_pkg::H_HIGH: begin
        next_state.div = state.div + 3'h1;
        if (state.div + 3'h1 == adc_pd_pkg::SCLK_HALF) begin
          next_state.div = 3'h0;
          next_state.sclk = 1'b1;
          if (state.falls == adc_pd_pkg::EDGE_LAST ||
              (state.op != adc_pd_pkg::OP_FULL &&
               state.falls == stop_edge)) begin
            next_state.st = adc_pd_pkg::H_END;
          end else begin
            next_state.st = adc_pd_pkg::H_LOW;
          end
        end
      end
      adc_pd_pkg::H_END: begin
        next_state.cs_n = 1'b1;
        next_state.quiet = 3'h0;
        if (state.op == adc_pd_pkg::OP_FULL) begin
          push = 1'b1;
        end
        next_state.st = adc_pd_pkg::H_QUIET;
      end
      adc_pd_pkg::H_QUIET: begin
        if (!pins[1]) begin
          next_state.quiet = state.quiet + 3'h1; // [R9]
        end
        if (state.quiet == adc_pd_pkg::QUIET_CYCLES) begin
          next_state.st = adc_pd_pkg::H_IDLE;
        end
      end
      default: next_state.st = adc_pd_pkg::H_IDLE;
    endcase
    if (push) begin
      next_state.buf_data[state.wr_ptr] = state.shreg[11:0]; // [R19]
      next_state.buf_valid[state.wr_ptr] = 1'b1;
      next_state.wr_ptr = !state.wr_ptr;
    end
    if (pop) begin
      next_state.buf_valid[state.rd_ptr] = 1'b0;
      next_state.rd_ptr = !state.rd_ptr;
    end
    next_state.ready = (next_state.st == adc_pd_pkg::H_IDLE) &&
      !(&next_state.buf_valid);
    next_state.head_valid = next_state.buf_valid[next_state.rd_ptr];
    next_state.head_data = next_state.buf_data[next_state.rd_ptr];
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= '0;
      state.st <= adc_pd_pkg::H_IDLE;
      state.cs_n <= 1'b1;
      state.sclk <= 1'b1;
      state.ready <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign link.frame_sel_n = state.cs_n;
  assign link.sclk = state.sclk;
  assign o_req_ready = state.ready;
  assign o_data_valid = state.head_valid;
  assign o_data = state.head_data;
endmodule
`default_nettype wire

// ==== verif/adc_link_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_link_monitor (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Link
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  logic sq;
  logic [4:0] cnt;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  // Link clock falls seen inside the frame
  always_ff @(posedge i_mclk) begin
    sq <= sclk;
    if (i_reset || frame_sel_n) cnt <= 5'h00;
    else if (sq && !sclk) cnt <= cnt + 5'h01;
  end
  property p_drive;
    $fell(frame_sel_n) |-> ##[1:6] serial_result_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("oe not driven");
  property p_zeros;
    serial_result_oe && !frame_sel_n && cnt < 5'h04
      |-> !serial_result_out;
  endproperty
  a_zeros: assert property (p_zeros) else $error("lead bit not 0");
  property p_end;
    cnt == 5'h10 && $past(cnt) == 5'h0F |-> ##[0:6] !serial_result_oe;
  endproperty
  a_end: assert property (p_end) else $error("oe kept after 16");
  property p_abort;
    $rose(frame_sel_n) |-> ##[0:6] !serial_result_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("oe kept on rise");
  property p_idle;
    frame_sel_n [*8] |-> !serial_result_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("oe outside frame");
  property p_quiet;
    $fell(serial_result_oe) |-> ##[0:8] frame_sel_n [*3];
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet too short");
  property p_len;
    !frame_sel_n |-> cnt <= 5'h10;
  endproperty
  a_len: assert property (p_len) else $error("frame too long");
  property p_rate;
    $changed(sclk) |=> $stable(sclk) [*3];
  endproperty
  a_rate: assert property (p_rate) else $error("clock too fast");
  property p_rise;
    $rose(frame_sel_n) |-> cnt >= 5'h02;
  endproperty
  a_rise: assert property (p_rise) else $error("early rise");
  c_pd: cover property ($rose(frame_sel_n) && cnt inside {[2:9]});
  c_stop: cover property ($rose(frame_sel_n) && cnt inside {[10:15]});
  c_full: cover property ($rose(frame_sel_n) && cnt == 5'h10);
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_mclk, i_reset, i_req_valid, i_data_ready, hold;
  adc_pd_pkg::op_type i_req_op;
  logic [11:0] i_sample, o_data, o_result, last_full;
  logic o_req_ready, o_data_valid, o_analog_on, o_tracking, o_powered;
  logic [31:0] seed = 32'hFE95EF00;
  logic [31:0] rs = 32'hFE95EF00;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [11:0] exp_q[$];
  adc_link_if link ();
  adc_pd_device adc_pd_device_i (.i_mclk(i_mclk), .i_reset(i_reset),
    .link(link), .i_sample(i_sample), .o_analog_on(o_analog_on),
    .o_tracking(o_tracking), .o_powered(o_powered), .o_result(o_result));
  adc_pd_host adc_pd_host_i (.i_mclk(i_mclk), .i_reset(i_reset),
    .link(link), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
    .o_req_ready(o_req_ready), .o_data_valid(o_data_valid),
    .o_data(o_data), .i_data_ready(i_data_ready));
  adc_link_monitor adc_link_monitor_i (.i_mclk(i_mclk),
    .i_reset(i_reset), .frame_sel_n(link.frame_sel_n),
    .sclk(link.sclk), .serial_result_out(link.serial_result_out),
    .serial_result_oe(link.serial_result_oe));
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk12(logic [11:0] g, logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(logic g, logic e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (o_req_ready !== 1'b1) begin
      @(negedge i_mclk);
      n++;
      if (n > 3000) begin
        error_cnt++;
        print_verdict();
      end
    end
  endtask
  task automatic req(adc_pd_pkg::op_type op);
    idle();
    seed = xs(seed);
    i_sample = seed[11:0];
    i_req_op = op;
    i_req_valid = 1'b1;
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    if (op == adc_pd_pkg::OP_FULL) begin
      exp_q.push_back(i_sample);
      last_full = i_sample;
    end
    @(negedge i_mclk);
  endtask
  task automatic wait_n(int n);
    repeat (n) @(negedge i_mclk);
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Result sink with random stalls
  always @(negedge i_mclk) begin
    rs = xs(rs);
    i_data_ready = !hold && rs[3];
    if (!i_reset && o_data_valid === 1'b1 && i_data_ready) begin
      chk12(o_data, exp_q.pop_front());
    end
  end
  initial begin
    i_reset = 1'b1;
    i_req_valid = 1'b0;
    i_req_op = adc_pd_pkg::OP_FULL;
    i_sample = 12'h000;
    i_data_ready = 1'b0;
    hold = 1'b0;
    wait_n(16);
    i_reset = 1'b0;
    chk1(o_tracking, 1'b1);
    req(adc_pd_pkg::OP_STOP_AFTER);
    idle();
    chk1(o_powered, 1'b1);
    repeat (3) req(adc_pd_pkg::OP_FULL);
    idle();
    chk12(o_result, last_full);
    req(adc_pd_pkg::OP_POWER_DOWN);
    idle();
    wait_n(8);
    chk1(o_analog_on, 1'b0);
    chk1(o_tracking, 1'b0);
    chk12(o_result, last_full);
    req(adc_pd_pkg::OP_POWER_DOWN);
    idle();
    wait_n(8);
    chk1(o_analog_on, 1'b0);
    chk1(o_powered, 1'b0);
    req(adc_pd_pkg::OP_STOP_AFTER);
    idle();
    wait_n(30);
    chk1(o_powered, 1'b1);
    chk1(o_analog_on, 1'b1);
    chk1(o_tracking, 1'b1);
    req(adc_pd_pkg::OP_FULL);
    req(adc_pd_pkg::OP_STOP_AFTER);
    idle();
    wait_n(8);
    chk1(o_powered, 1'b1);
    wait_n(300);
    hold = 1'b1;
    req(adc_pd_pkg::OP_FULL);
    req(adc_pd_pkg::OP_FULL);
    wait_n(250);
    chk1(o_req_ready, 1'b0);
    chk1(o_data_valid, 1'b1);
    hold = 1'b0;
    wait_n(400);
    chk1(exp_q.size() == 0, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
